// *** mrdp_pkg.sv ***
// constants and carrier types shared by the mii/rmii data port
package mrdp_pkg;

	// ****************************************
	// divider counts, in reference clock edges
	// ****************************************
	// generated mii clock: half period in ref edges (50 MHz ref -> 25 MHz)
	localparam logic [3:0] DCE_HALF_100 = 4'h1;
	// generated mii clock: half period in ref edges (50 MHz ref -> 2.5 MHz)
	localparam logic [3:0] DCE_HALF_10  = 4'hA;
	// rmii 10 Mbps: one symbol every this many ref periods
	localparam logic [3:0] RMII_SLOW_DIV = 4'hA;

	// ****************************************
	// reset values and the rmii dibit mask
	// ****************************************
	localparam logic [3:0] CNT_RST  = 4'h0;
	localparam logic [3:0] NIB_RST  = 4'h0;
	localparam logic       BIT_RST  = 1'b0;
	localparam logic [1:0] DIBIT_MASK = 2'h3;

	// ****************************************
	// carriers
	// ****************************************
	// pins sampled together from the phy side
	typedef struct packed {
		logic       ref_clk;
		logic       tx_clk;
		logic       rx_clk;
		logic       rx_dv;
		logic       rx_er;
		logic [3:0] rxd;
	} mrdp_pins_t;

	// one received symbol handed to the user side
	typedef struct packed {
		logic [3:0] data;
		logic       err;
	} mrdp_rx_t;

	localparam mrdp_pins_t PINS_RST = '{BIT_RST, BIT_RST, BIT_RST, BIT_RST, BIT_RST, NIB_RST};

endpackage : mrdp_pkg

// *** mrdp_buf.sv ***
// small valid/ready buffer held in flip-flops
`timescale 1ns/1ps
module mrdp_buf #(
	parameter int W     = 5,
	parameter int DEPTH = 2
) (
	// clock and reset
	input  wire logic         clk,
	input  wire logic         rst,
	// fill side
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	// drain side
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);
	import mrdp_pkg::*;

	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam logic [AW:0]   FULL_CNT = (AW+1)'(DEPTH);
	localparam logic [AW-1:0] LAST_IDX = AW'(DEPTH - 1);

	logic [W-1:0]  mem_ff [DEPTH];
	logic [W-1:0]  nxt_mem [DEPTH];
	logic [AW-1:0] wr_ff;
	logic [AW-1:0] nxt_wr;
	logic [AW-1:0] rd_ff;
	logic [AW-1:0] nxt_rd;
	logic [AW:0]   cnt_ff;
	logic [AW:0]   nxt_cnt;
	logic          push;
	logic          pop;

	assign in_ready  = (cnt_ff != FULL_CNT);
	assign out_valid = (cnt_ff != '0);
	assign out_data  = mem_ff[rd_ff];

	always_comb
	begin
		push    = in_valid && in_ready;
		pop     = out_valid && out_ready;
		nxt_mem = mem_ff;
		nxt_wr  = wr_ff;
		nxt_rd  = rd_ff;
		nxt_cnt = cnt_ff;
		if (push)
		begin
			nxt_mem[wr_ff] = in_data;
			nxt_wr         = (wr_ff == LAST_IDX) ? '0 : wr_ff + AW'(1);
		end
		if (pop)
			nxt_rd = (rd_ff == LAST_IDX) ? '0 : rd_ff + AW'(1);
		if (push && !pop)
			nxt_cnt = cnt_ff + (AW+1)'(1);
		else if (pop && !push)
			nxt_cnt = cnt_ff - (AW+1)'(1);
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			for (int i = 0; i < DEPTH; i++)
				mem_ff[i] <= '0;
			wr_ff  <= '0;
			rd_ff  <= '0;
			cnt_ff <= '0;
		end
		else
		begin
			mem_ff <= nxt_mem;
			wr_ff  <= nxt_wr;
			rd_ff  <= nxt_rd;
			cnt_ff <= nxt_cnt;
		end
	end

endmodule : mrdp_buf

// *** mrdp_port.sv ***
// mii/rmii transmit and receive pin logic of one ethernet mac port
`timescale 1ns/1ps
module mrdp_port (
	// clock and reset
	input  wire logic              SYS_CLK,
	input  wire logic              RST,
	// configuration levels
	input  wire logic              MODE_RMII,
	input  wire logic              MODE_DCE,
	input  wire logic              SPEED_100,
	// reference clock
	input  wire logic              REF_CLK,
	// mii clocks, two-way
	input  wire logic              TX_CLK_I,
	output logic                   TX_CLK_O,
	output logic                   TX_CLK_OE,
	input  wire logic              RX_CLK_I,
	output logic                   RX_CLK_O,
	output logic                   RX_CLK_OE,
	// transmit pins
	output logic                   TX_EN,
	output logic [3:0]             TXD,
	// receive pins (RX_DV is CRS_DV in rmii)
	input  wire logic              RX_DV,
	input  wire logic              RX_ER,
	input  wire logic [3:0]        RXD,
	// user transmit stream
	input  wire logic              TX_VALID,
	output logic                   TX_READY,
	input  wire logic [3:0]        TX_DATA,
	// user receive stream
	output logic                   RX_VALID,
	input  wire logic              RX_READY,
	output mrdp_pkg::mrdp_rx_t     RX_DATA,
	output logic                   RX_OVERRUN
);
	import mrdp_pkg::*;

	// ****************************************
	// pin synchronisers
	// ****************************************
	mrdp_pins_t pins_raw;
	mrdp_pins_t s1_ff;
	mrdp_pins_t s2_ff;
	mrdp_pins_t s3_ff;
	mrdp_pins_t filt_ff;
	mrdp_pins_t nxt_filt;
	logic       ref_prev_ff;
	logic       txc_prev_ff;
	logic       rxc_prev_ff;
	logic       ref_rise;
	logic       txc_rise;
	logic       rxc_rise;

	assign pins_raw = '{REF_CLK, TX_CLK_I, RX_CLK_I, RX_DV, RX_ER, RXD};

	// a bit only moves once the last two stages agree
	always_comb
	begin
		nxt_filt = (s2_ff & s3_ff) | (filt_ff & (s2_ff | s3_ff));
	end

	always_ff @(posedge SYS_CLK or posedge RST)
	begin
		if (RST)
		begin
			s1_ff       <= PINS_RST;
			s2_ff       <= PINS_RST;
			s3_ff       <= PINS_RST;
			filt_ff     <= PINS_RST;
			ref_prev_ff <= BIT_RST;
			txc_prev_ff <= BIT_RST;
			rxc_prev_ff <= BIT_RST;
		end
		else
		begin
			s1_ff       <= pins_raw;
			s2_ff       <= s1_ff;
			s3_ff       <= s2_ff;
			filt_ff     <= nxt_filt;
			ref_prev_ff <= filt_ff.ref_clk;
			txc_prev_ff <= filt_ff.tx_clk;
			rxc_prev_ff <= filt_ff.rx_clk;
		end
	end

	assign ref_rise = filt_ff.ref_clk & ~ref_prev_ff;
	assign txc_rise = filt_ff.tx_clk & ~txc_prev_ff;
	assign rxc_rise = filt_ff.rx_clk & ~rxc_prev_ff;

	// ****************************************
	// dce clock generation and rmii divider
	// ****************************************
	logic [3:0] gen_cnt_ff;
	logic [3:0] nxt_gen_cnt;
	logic       gen_clk_ff;
	logic       nxt_gen_clk;
	logic       gen_rise;
	logic       gen_fall;
	logic [3:0] gen_half;
	logic [3:0] rdiv_ff;
	logic [3:0] nxt_rdiv;
	logic       rmii_tick;
	logic       mii_dce;

	assign mii_dce  = MODE_DCE & ~MODE_RMII;
	assign gen_half = SPEED_100 ? DCE_HALF_100 : DCE_HALF_10;

	always_comb
	begin
		nxt_gen_cnt = gen_cnt_ff;
		nxt_gen_clk = gen_clk_ff;
		gen_rise    = 1'b0;
		gen_fall    = 1'b0;
		nxt_rdiv    = rdiv_ff;
		rmii_tick   = 1'b0;
		if (ref_rise)
		begin
			// both mii clocks derive from ref in dce
			if (gen_cnt_ff >= gen_half - 4'h1)
			begin
				nxt_gen_cnt = CNT_RST;
				nxt_gen_clk = ~gen_clk_ff;
				gen_rise    = ~gen_clk_ff;
				gen_fall    = gen_clk_ff;
			end
			else
				nxt_gen_cnt = gen_cnt_ff + 4'h1;
			// slow rmii takes one ref period in ten
			nxt_rdiv  = (rdiv_ff >= RMII_SLOW_DIV - 4'h1) ? CNT_RST : rdiv_ff + 4'h1;
			rmii_tick = SPEED_100 || (rdiv_ff == CNT_RST);
		end
	end

	always_ff @(posedge SYS_CLK or posedge RST)
	begin
		if (RST)
		begin
			gen_cnt_ff <= CNT_RST;
			gen_clk_ff <= BIT_RST;
			rdiv_ff    <= CNT_RST;
		end
		else
		begin
			gen_cnt_ff <= nxt_gen_cnt;
			gen_clk_ff <= nxt_gen_clk;
			rdiv_ff    <= nxt_rdiv;
		end
	end

	// generated clock drives both pins only in mii dce
	assign TX_CLK_O  = gen_clk_ff;
	assign RX_CLK_O  = gen_clk_ff;
	assign TX_CLK_OE = mii_dce;
	assign RX_CLK_OE = mii_dce;

	// ****************************************
	// symbol ticks
	// ****************************************
	logic tx_tick;
	logic rx_tick;

	always_comb
	begin
		if (MODE_RMII)
		begin
			tx_tick = rmii_tick;
			rx_tick = rmii_tick;
		end
		else if (MODE_DCE)
		begin
			// launch on our falling edge so data stands at the phy's rising sample
			tx_tick = gen_fall;
			rx_tick = gen_rise;
		end
		else
		begin
			tx_tick = txc_rise;
			rx_tick = rxc_rise;
		end
	end

	// ****************************************
	// transmit path
	// ****************************************
	logic       txb_valid;
	logic       txb_pop;
	logic [3:0] txb_data;
	logic [3:0] txd_ff;
	logic [3:0] nxt_txd;
	logic       txen_ff;
	logic       nxt_txen;

	mrdp_buf #(
		.W     (4),
		.DEPTH (2)
	) u_tx_buf (
		.clk       (SYS_CLK),
		.rst       (RST),
		.in_valid  (TX_VALID),
		.in_ready  (TX_READY),
		.in_data   (TX_DATA),
		.out_valid (txb_valid),
		.out_ready (txb_pop),
		.out_data  (txb_data)
	);

	// frame ends when the user lets the buffer run dry at a tick
	always_comb
	begin
		nxt_txd  = txd_ff;
		nxt_txen = txen_ff;
		txb_pop  = 1'b0;
		if (tx_tick)
		begin
			txb_pop  = txb_valid;
			nxt_txen = txb_valid;
			if (!txb_valid)
				nxt_txd = NIB_RST;
			else if (MODE_RMII)
				nxt_txd = {2'h0, txb_data[1:0] & DIBIT_MASK};
			else
				nxt_txd = txb_data;
		end
	end

	// outputs only move on a tick, so slow rmii holds for ten periods
	always_ff @(posedge SYS_CLK or posedge RST)
	begin
		if (RST)
		begin
			txd_ff  <= NIB_RST;
			txen_ff <= BIT_RST;
		end
		else
		begin
			txd_ff  <= nxt_txd;
			txen_ff <= nxt_txen;
		end
	end

	assign TXD   = txd_ff;
	assign TX_EN = txen_ff;

	// ****************************************
	// receive path
	// ****************************************
	mrdp_rx_t rx_word;
	logic     rx_push;
	logic     rxb_ready;
	logic     ovr_ff;
	logic     nxt_ovr;

	always_comb
	begin
		rx_word.err  = filt_ff.rx_er;
		rx_word.data = MODE_RMII ? {2'h0, filt_ff.rxd[1:0]} : filt_ff.rxd;
		// symbols with dv low are dropped
		rx_push      = rx_tick && filt_ff.rx_dv;
		// phy cannot be stalled; a full buffer loses the symbol
		nxt_ovr      = rx_push && !rxb_ready;
	end

	always_ff @(posedge SYS_CLK or posedge RST)
	begin
		if (RST)
			ovr_ff <= BIT_RST;
		else
			ovr_ff <= nxt_ovr;
	end

	mrdp_buf #(
		.W     ($bits(mrdp_rx_t)),
		.DEPTH (2)
	) u_rx_buf (
		.clk       (SYS_CLK),
		.rst       (RST),
		.in_valid  (rx_push),
		.in_ready  (rxb_ready),
		.in_data   (rx_word),
		.out_valid (RX_VALID),
		.out_ready (RX_READY),
		.out_data  (RX_DATA)
	);

	assign RX_OVERRUN = ovr_ff;

endmodule : mrdp_port

// *** mrdp_checker.sv ***
// pin and stream assertions for the mii/rmii data port
`timescale 1ns/1ps
module mrdp_checker
	import mrdp_pkg::*;
(
	// clock and reset
	input wire logic               SYS_CLK,
	input wire logic               RST,
	// configuration
	input wire logic               MODE_RMII,
	input wire logic               MODE_DCE,
	// pins
	input wire logic               TX_CLK_O,
	input wire logic               TX_CLK_OE,
	input wire logic               RX_CLK_OE,
	input wire logic               TX_EN,
	input wire logic [3:0]         TXD,
	input wire logic               RX_DV,
	// user receive stream
	input wire logic               RX_VALID,
	input wire logic               RX_READY,
	input wire mrdp_pkg::mrdp_rx_t RX_DATA,
	input wire logic               RX_OVERRUN
);
	// ****************
	// cycles since valid seen high
	// ****************
	logic [5:0] dv_idle_ff;
	logic [5:0] nxt_dv_idle;
	always_comb
	begin
		nxt_dv_idle = RX_DV ? 6'h00 : dv_idle_ff + {5'h00, dv_idle_ff != 6'h3F};
	end
	always_ff @(posedge SYS_CLK or posedge RST)
	begin
		if (RST)
			dv_idle_ff <= 6'h3F;
		else
			dv_idle_ff <= nxt_dv_idle;
	end
	// ****************
	// properties
	// ****************
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (RST);
	a_txd_upper_zero: assert property (MODE_RMII |-> TXD[3:2] == 2'h0)
		else $error("upper transmit bits driven in rmii");
	a_txd_idle_zero: assert property (!TX_EN |-> TXD == 4'h0)
		else $error("transmit data without enable");
	a_rx_data_hold: assert property (RX_VALID && !RX_READY |=> RX_VALID && $stable(RX_DATA))
		else $error("receive symbol lost before taken");
	a_tx_clk_dir: assert property (TX_CLK_OE == (MODE_DCE && !MODE_RMII))
		else $error("transmit clock direction wrong");
	a_rx_clk_dir: assert property (RX_CLK_OE == (MODE_DCE && !MODE_RMII))
		else $error("receive clock direction wrong");
	a_rx_needs_dv: assert property ($rose(RX_VALID) |-> dv_idle_ff <= 6'h03)
		else $error("symbol accepted with valid low");
	a_ovr_when_full: assert property (RX_OVERRUN |-> RX_VALID)
		else $error("overrun while buffer not full");
	a_dce_clk_runs: assert property (MODE_DCE && !MODE_RMII |-> ##[1:40] $changed(TX_CLK_O))
		else $error("generated clock stopped");
	c_tx_frame: cover property ($rose(TX_EN));
	c_rx_pop: cover property (RX_VALID && RX_READY);
	c_rx_ovr: cover property (RX_OVERRUN);
endmodule : mrdp_checker

bind mrdp_port mrdp_checker mrdp_checker_i (.SYS_CLK, .RST, .MODE_RMII, .MODE_DCE, .TX_CLK_O, .TX_CLK_OE,
	.RX_CLK_OE, .TX_EN, .TXD, .RX_DV, .RX_VALID, .RX_READY, .RX_DATA, .RX_OVERRUN);

// *** mrdp_phy_model.sv ***
// behavioural phy: free-running link clock and transmit capture
`timescale 1ns/1ps
module mrdp_phy_model (
	// link side
	output logic             lclk,
	input  wire logic        cclk,
	input  wire logic        slow,
	input  wire logic        rmii,
	input  wire logic        tx_en,
	input  wire logic [3:0]  txd,
	// captured symbols
	output logic             cap_v,
	output logic [3:0]       cap_d
);
	// ****************
	// clock and capture
	// ****************
	initial
	begin
		lclk = 1'b0;
		forever #62.5 lclk = ~lclk;
	end
	// slow rmii: one capture per ten link periods, any phase
	logic [3:0] scnt = 4'h0;
	always @(posedge cclk)
	begin
		cap_v <= (!slow || scnt == 4'h0) ? tx_en : 1'b0;
		cap_d <= rmii ? {2'h0, txd[1:0]} : txd;
		scnt  <= (!slow || scnt == 4'h9) ? 4'h0 : scnt + 4'h1;
	end
endmodule : mrdp_phy_model

// *** tb.sv ***
// self-checking bench for the mii/rmii data port
`timescale 1ns/1ps
module tb;
	import mrdp_pkg::*;
	logic SYS_CLK, RST, MODE_RMII, MODE_DCE, SPEED_100, TX_VALID, RX_READY, RX_DV, RX_ER;
	logic TX_READY, TX_EN, RX_VALID, RX_OVERRUN, TX_CLK_O, TX_CLK_OE, RX_CLK_O, RX_CLK_OE;
	logic [3:0] TX_DATA, RXD, TXD;
	mrdp_rx_t RX_DATA;
	logic lclk, cap_v, tx_on, rx_on, hold;
	logic [3:0] cap_d, sdiv;
	logic [31:0] rnd;
	logic [4:0] nheld, exp_ovr, ovr_seen;
	logic [3:0] tx_q[$];
	mrdp_rx_t rx_q[$];
	int bad_count, cmp_count;
	wire tx_clk_w = TX_CLK_OE ? TX_CLK_O : lclk;
	wire rx_clk_w = RX_CLK_OE ? RX_CLK_O : lclk;

	mrdp_port mrdp_port_i (.SYS_CLK, .RST, .MODE_RMII, .MODE_DCE, .SPEED_100, .REF_CLK(lclk),
		.TX_CLK_I(tx_clk_w), .TX_CLK_O, .TX_CLK_OE, .RX_CLK_I(rx_clk_w), .RX_CLK_O, .RX_CLK_OE,
		.TX_EN, .TXD, .RX_DV, .RX_ER, .RXD, .TX_VALID, .TX_READY, .TX_DATA, .RX_VALID, .RX_READY,
		.RX_DATA, .RX_OVERRUN);
	mrdp_phy_model mrdp_phy_model_i (.lclk, .cclk(tx_clk_w), .slow(MODE_RMII & !SPEED_100), .rmii(MODE_RMII),
		.tx_en(TX_EN), .txd(TXD), .cap_v, .cap_d);

	// ****************
	// helpers
	// ****************
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	task automatic check(input logic [4:0] seen, input logic [4:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic give_verdict;
		$display("comparisons %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : give_verdict
	// reset into a mode, stream both ways, then drain
	task automatic run_mode(input logic r, input logic d, input logic s);
		RST <= 1'b1;
		MODE_RMII <= r;
		MODE_DCE <= d;
		SPEED_100 <= s;
		repeat (12) @(posedge SYS_CLK);
		RST <= 1'b0;
		tx_on = 1'b1;
		rx_on = 1'b1;
		repeat (3000) @(posedge SYS_CLK);
		tx_on = 1'b0;
		rx_on = 1'b0;
		repeat (1500) @(posedge SYS_CLK);
		check(5'(tx_q.size()), 5'h00);
		check(5'(rx_q.size()), 5'h00);
		$display("mode rmii=%0d dce=%0d fast=%0d done", r, d, s);
	endtask : run_mode

	// ****************
	// drivers and monitors
	// ****************
	always @(posedge SYS_CLK)
	begin
		if (TX_VALID && TX_READY)
			tx_q.push_back(MODE_RMII ? {2'h0, TX_DATA[1:0]} : TX_DATA);
		if (!TX_VALID || TX_READY)
		begin
			TX_VALID <= tx_on & rnd[3];
			TX_DATA <= rnd[7:4];
		end
		RX_READY <= !hold & rnd[9];
		rnd <= lfsr(rnd);
		if (RX_VALID === 1'b1 && RX_READY === 1'b1)
			check(RX_DATA, rx_q.size() ? rx_q.pop_front() : 'x);
		if (RX_OVERRUN === 1'b1)
			ovr_seen++;
	end
	// phy side changes on the falling link edge, stable at the rising one
	// slow rmii: each symbol stands ten link periods
	always @(negedge rx_clk_w)
	begin
		@(posedge SYS_CLK);
		if (SPEED_100 || !MODE_RMII || sdiv == 4'h0)
		begin
			RX_DV <= rx_on & rnd[11];
			RX_ER <= rnd[16];
			RXD <= rnd[15:12];
			if (rx_on && rnd[11])
			begin
				if (hold && nheld == 5'h02)
					exp_ovr++;
				else
				begin
					rx_q.push_back({MODE_RMII ? {2'h0, rnd[13:12]} : rnd[15:12], rnd[16]});
					nheld = nheld + {4'h0, hold};
				end
			end
		end
		sdiv = (sdiv == 4'h9) ? 4'h0 : sdiv + 4'h1;
	end
	always @(posedge tx_clk_w)
	begin
		#1;
		if (cap_v === 1'b1)
			check({1'b0, cap_d}, {1'b0, tx_q.size() ? tx_q.pop_front() : 4'hx});
	end

	// ****************
	// clock, sequence, watchdog
	// ****************
	initial
	begin
		SYS_CLK = 1'b0;
		forever #2 SYS_CLK = ~SYS_CLK;
	end
	initial
	begin
		{RST, MODE_RMII, MODE_DCE, SPEED_100} = 4'hB;
		{TX_VALID, RX_READY, RX_DV, RX_ER, tx_on, rx_on, hold} = 7'h00;
		{TX_DATA, RXD} = 8'h00;
		sdiv = 4'h0;
		{nheld, exp_ovr, ovr_seen} = 15'h0000;
		rnd = 32'h8fba;
		run_mode(1'b0, 1'b0, 1'b1);
		run_mode(1'b1, 1'b0, 1'b1);
		hold = 1'b1;
		rx_on = 1'b1;
		repeat (600) @(posedge SYS_CLK);
		rx_on = 1'b0;
		repeat (100) @(posedge SYS_CLK);
		check(ovr_seen, exp_ovr);
		hold = 1'b0;
		repeat (300) @(posedge SYS_CLK);
		check(5'(rx_q.size()), 5'h00);
		$display("overrun done");
		run_mode(1'b1, 1'b0, 1'b0);
		run_mode(1'b0, 1'b1, 1'b1);
		give_verdict();
	end
	initial
	begin
		#120000;
		bad_count++;
		give_verdict();
	end
endmodule : tb
